/* File: hdl/usd_pkg.sv */
// constants, types and helpers shared by the uart shadow data port
// Overview of operation
// - the receive and transmit data path answer identically at sixteen aligned 32-bit alias words.
// - an alias read returns the received byte in bits 7:0, taken from the serial or the infrared input.
// - received data is valid only while the data ready flag of line status is set.
// - with the fifo off a new character overwrites an unread byte and flags an overrun.
// - with the fifo on an alias read returns and removes the head of the receive fifo.
// - a character that arrives at a full receive fifo with no alias read in the same cycle is dropped, the fifo kept and an overrun flagged.
// - an alias write sends its byte on the serial output, or on the infrared output in infrared mode.
// - with the fifo off a write clears the holding empty flag.
// - with the fifo off a write before the holding empty flag returns overwrites the pending byte.
// - with the fifo on sixteen writes are accepted before the transmit fifo is full.
// - a write while the transmit fifo is full and the transmitter loads no byte in the same cycle is dropped and leaves the fifo unchanged.
package usd_pkg;
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned BAUD_HZ = 115_200;
	localparam logic [7:0] BIT_CYC = 8'(CLK_HZ / BAUD_HZ);
	localparam logic [7:0] HALF_CYC = 8'(CLK_HZ / BAUD_HZ / 2);
	localparam logic [7:0] IR_CYC = 8'(CLK_HZ / BAUD_HZ * 3 / 16);
	localparam int unsigned FIFO_DEPTH = 16;
	localparam int unsigned PTR_W = 4;
	localparam logic [31:0] ALIAS_BASE = 32'h5000_1030;
	localparam logic [31:0] ALIAS_SPAN = 32'h0000_0040;
	localparam logic [31:0] ALIAS_FIVE = 32'h5000_1044;
	localparam logic [31:0] ALIAS_SIX = 32'h5000_1048;
	localparam logic [31:0] CTRL_ADDR = 32'h5000_1080;
	localparam logic [31:0] LSR_ADDR = 32'h5000_1084;
	localparam logic [31:0] INT_STAT_ADDR = 32'h5000_1088;
	localparam logic [31:0] INT_CLR_ADDR = 32'h5000_108c;
	localparam logic [31:0] INT_EN_ADDR = 32'h5000_1090;
	localparam int unsigned FC_FIFO_EN = 0;
	localparam int unsigned FC_IR_MODE = 1;
	localparam int unsigned LS_DR = 0;
	localparam int unsigned LS_OE = 1;
	localparam int unsigned LS_TX_HOLDING_EMPTY_FLAG = 5;
	localparam int unsigned LS_TEMT = 6;
	localparam int unsigned EV_RX = 0;
	localparam int unsigned EV_OE = 1;
	localparam int unsigned EV_TX_HOLDING_EMPTY_FLAG = 2;
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam logic [2:0] INT_RST = 3'h0;
	localparam logic [7:0] BYTE_RST = 8'h00;

	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} usd_bus_req_s;

	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} usd_rx_state_e;
	typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} usd_tx_state_e;

	function automatic logic usd_is_alias(input logic [31:0] addr);
		usd_is_alias = (addr >= ALIAS_BASE) && (addr < ALIAS_BASE + ALIAS_SPAN) && (addr[1:0] == 2'h0);
	endfunction : usd_is_alias
endpackage : usd_pkg

/* File: hdl/usd_sync.sv */
// three flop input synchroniser with agreement filter
`timescale 1ns/1ns
module usd_sync #(
	parameter logic RST_VAL = 1'b1
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// pin and filtered level
	input wire logic async_i,
	output logic level_o
);
	logic s1;
	logic s2;
	logic s3;

	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			s1 <= RST_VAL;
			s2 <= RST_VAL;
			s3 <= RST_VAL;
			level_o <= RST_VAL;
		end
		else
		begin
			s1 <= async_i;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3)
			begin
				level_o <= s3;
			end
		end
	end
endmodule : usd_sync

/* File: hdl/usd_fifo.sv */
// byte fifo held in flip-flops
`timescale 1ns/1ns
module usd_fifo (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// control
	input wire logic clear_i,
	input wire logic push_i,
	input wire logic pop_i,
	// data and status
	input wire logic [7:0] data_i,
	output logic [7:0] data_o,
	output logic full_o,
	output logic empty_o
);
	import usd_pkg::*;

	logic [7:0] mem [FIFO_DEPTH];
	logic [PTR_W-1:0] wr_idx;
	logic [PTR_W-1:0] rd_idx;
	logic [PTR_W:0] count;
	logic do_push;
	logic do_pop;

	assign do_pop = pop_i && (count != '0);
	assign do_push = push_i && ((count != (PTR_W+1)'(FIFO_DEPTH)) || do_pop);
	assign full_o = (count == (PTR_W+1)'(FIFO_DEPTH));
	assign empty_o = (count == '0);
	assign data_o = mem[rd_idx];

	always_ff @(posedge sys_clk_i)
	begin
		if (do_push)
		begin
			mem[wr_idx] <= data_i;
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i || clear_i)
		begin
			wr_idx <= '0;
			rd_idx <= '0;
			count <= '0;
		end
		else
		begin
			if (do_push)
			begin
				wr_idx <= wr_idx + 1'b1;
			end
			if (do_pop)
			begin
				rd_idx <= rd_idx + 1'b1;
			end
			if (do_push && !do_pop)
			begin
				count <= count + 1'b1;
			end
			else if (do_pop && !do_push)
			begin
				count <= count - 1'b1;
			end
		end
	end
endmodule : usd_fifo

/* File: hdl/usd_top.sv */
// uart shadow data alias with receive and transmit paths
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ns
module usd_top (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// register port
	input wire usd_pkg::usd_bus_req_s bus_req_i,
	output logic [31:0] rd_data_o,
	// serial line
	input wire logic serial_input_pin_i,
	input wire logic infrared_rx_input_i,
	output logic serial_output_pin_o,
	output logic infrared_tx_output_low_o,
	// interrupt
	output logic irq_o
);
	import usd_pkg::*;

	logic [1:0] fifo_control;
	logic fifo_en;
	logic ir_mode;
	logic alias_hit;
	logic alias_rd;
	logic alias_wr;
	logic ctrl_wr;
	logic lsr_rd;
	logic mode_chg;
	logic sin_lvl;
	logic ir_lvl;
	logic ir_hold;
	logic rx_line;
	usd_rx_state_e rx_state;
	logic [7:0] rx_cnt;
	logic [2:0] rx_idx;
	logic [7:0] rx_shift;
	logic rx_done;
	logic rx_sample;
	logic [7:0] receive_buffer;
	logic dr_nf;
	logic rx_push;
	logic rx_pop;
	logic [7:0] rx_head;
	logic rx_full;
	logic rx_empty;
	logic rx_data_ready_flag;
	logic ov_ev;
	logic overrun;
	logic [7:0] transmit_holding;
	logic thr_full;
	logic tx_push;
	logic tx_load;
	logic [7:0] tx_head;
	logic tx_full;
	logic tx_empty;
	logic have_data;
	logic tx_holding_empty_flag;
	logic tx_holding_empty_flag_q;
	usd_tx_state_e tx_state;
	logic [7:0] tx_cnt;
	logic [2:0] tx_idx;
	logic [7:0] tx_shift;
	logic tx_bit;
	logic [7:0] line_status;
	logic [2:0] events;
	logic [2:0] int_stat;
	logic [2:0] int_en;

	// register decode
	assign fifo_en = fifo_control[FC_FIFO_EN];
	assign ir_mode = fifo_control[FC_IR_MODE];
	assign alias_hit = usd_is_alias(bus_req_i.addr);
	assign alias_rd = bus_req_i.rd && alias_hit;
	assign alias_wr = bus_req_i.wr && alias_hit;
	assign ctrl_wr = bus_req_i.wr && (bus_req_i.addr == CTRL_ADDR);
	assign lsr_rd = bus_req_i.rd && (bus_req_i.addr == LSR_ADDR);
	assign mode_chg = ctrl_wr && (bus_req_i.wdata[FC_FIFO_EN] != fifo_en);

	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			fifo_control <= CTRL_RST;
		end
		else if (ctrl_wr)
		begin
			fifo_control <= bus_req_i.wdata[1:0];
		end
	end

	// input pins
	usd_sync #(
		.RST_VAL(1'b1)
	) u_sin_sync (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.async_i(serial_input_pin_i),
		.level_o(sin_lvl)
	);

	usd_sync #(
		.RST_VAL(1'b0)
	) u_ir_sync (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.async_i(infrared_rx_input_i),
		.level_o(ir_lvl)
	);

	// an infrared zero is a short pulse, so hold it until the bit is sampled
	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			ir_hold <= 1'b0;
		end
		else if (ir_lvl)
		begin
			ir_hold <= 1'b1;
		end
		else if (rx_sample)
		begin
			ir_hold <= 1'b0;
		end
	end

	assign rx_line = ir_mode ? !(ir_lvl || ir_hold) : sin_lvl;
	assign rx_sample = (rx_state != RX_IDLE) && (rx_cnt == 8'h00);

	// receive deserialiser, 8 data bits, one stop bit
	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			rx_state <= RX_IDLE;
			rx_cnt <= 8'h00;
			rx_idx <= 3'h0;
			rx_shift <= BYTE_RST;
			rx_done <= 1'b0;
		end
		else
		begin
			rx_done <= 1'b0;
			if (rx_state != RX_IDLE && !rx_sample)
			begin
				rx_cnt <= rx_cnt - 8'h01;
			end
			unique case (rx_state)
				RX_IDLE:
				begin
					if (!rx_line)
					begin
						rx_state <= RX_START;
						rx_cnt <= HALF_CYC;
					end
				end
				RX_START:
				begin
					if (rx_sample)
					begin
						rx_cnt <= BIT_CYC - 8'h01;
						rx_idx <= 3'h0;
						rx_state <= rx_line ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA:
				begin
					if (rx_sample)
					begin
						rx_shift <= {rx_line, rx_shift[7:1]};
						rx_cnt <= BIT_CYC - 8'h01;
						rx_idx <= rx_idx + 3'h1;
						if (rx_idx == 3'h7)
						begin
							rx_state <= RX_STOP;
						end
					end
				end
				RX_STOP:
				begin
					if (rx_sample)
					begin
						rx_done <= 1'b1;
						rx_state <= RX_IDLE;
					end
				end
			endcase
		end
	end

	// receive storage
	assign rx_pop = alias_rd && fifo_en;
	assign rx_push = rx_done && fifo_en;
	assign ov_ev = rx_done && (fifo_en ? (rx_full && !rx_pop) : dr_nf);

	usd_fifo u_rx_fifo (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.clear_i(mode_chg),
		.push_i(rx_push),
		.pop_i(rx_pop),
		.data_i(rx_shift),
		.data_o(rx_head),
		.full_o(rx_full),
		.empty_o(rx_empty)
	);

	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			receive_buffer <= BYTE_RST;
		end
		else if (rx_done && !fifo_en)
		begin
			receive_buffer <= rx_shift;
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i || mode_chg)
		begin
			dr_nf <= 1'b0;
		end
		else if (rx_done && !fifo_en)
		begin
			dr_nf <= 1'b1;
		end
		else if (alias_rd)
		begin
			dr_nf <= 1'b0;
		end
	end

	assign rx_data_ready_flag = fifo_en ? !rx_empty : dr_nf;

	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			overrun <= 1'b0;
		end
		else if (ov_ev)
		begin
			overrun <= 1'b1;
		end
		else if (lsr_rd)
		begin
			overrun <= 1'b0;
		end
	end

	// transmit storage
	assign tx_push = alias_wr && fifo_en;
	assign have_data = fifo_en ? !tx_empty : thr_full;
	assign tx_holding_empty_flag = !have_data;
	assign tx_load = (tx_state == TX_IDLE) && have_data;

	usd_fifo u_tx_fifo (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.clear_i(mode_chg),
		.push_i(tx_push),
		.pop_i(tx_load && fifo_en),
		.data_i(bus_req_i.wdata[7:0]),
		.data_o(tx_head),
		.full_o(tx_full),
		.empty_o(tx_empty)
	);

	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			transmit_holding <= BYTE_RST;
		end
		else if (alias_wr && !fifo_en)
		begin
			transmit_holding <= bus_req_i.wdata[7:0];
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i || mode_chg)
		begin
			thr_full <= 1'b0;
		end
		else if (alias_wr && !fifo_en)
		begin
			thr_full <= 1'b1;
		end
		else if (tx_load)
		begin
			thr_full <= 1'b0;
		end
	end

	// transmit serialiser
	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			tx_state <= TX_IDLE;
			tx_cnt <= 8'h00;
			tx_idx <= 3'h0;
			tx_shift <= BYTE_RST;
			tx_bit <= 1'b1;
		end
		else
		begin
			if (tx_state != TX_IDLE && tx_cnt != 8'h00)
			begin
				tx_cnt <= tx_cnt - 8'h01;
			end
			unique case (tx_state)
				TX_IDLE:
				begin
					if (tx_load)
					begin
						tx_shift <= fifo_en ? tx_head : transmit_holding;
						tx_cnt <= BIT_CYC - 8'h01;
						tx_bit <= 1'b0;
						tx_state <= TX_START;
					end
				end
				TX_START:
				begin
					if (tx_cnt == 8'h00)
					begin
						tx_cnt <= BIT_CYC - 8'h01;
						tx_bit <= tx_shift[0];
						tx_shift <= {1'b0, tx_shift[7:1]};
						tx_idx <= 3'h0;
						tx_state <= TX_DATA;
					end
				end
				TX_DATA:
				begin
					if (tx_cnt == 8'h00)
					begin
						tx_cnt <= BIT_CYC - 8'h01;
						tx_idx <= tx_idx + 3'h1;
						if (tx_idx == 3'h7)
						begin
							tx_bit <= 1'b1;
							tx_state <= TX_STOP;
						end
						else
						begin
							tx_bit <= tx_shift[0];
							tx_shift <= {1'b0, tx_shift[7:1]};
						end
					end
				end
				TX_STOP:
				begin
					if (tx_cnt == 8'h00)
					begin
						tx_state <= TX_IDLE;
					end
				end
			endcase
		end
	end

	// line drivers; an infrared zero is a low pulse over the first part of the bit
	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			serial_output_pin_o <= 1'b1;
			infrared_tx_output_low_o <= 1'b1;
		end
		else
		begin
			serial_output_pin_o <= ir_mode ? 1'b1 : tx_bit;
			infrared_tx_output_low_o <= !(ir_mode && !tx_bit && (tx_cnt >= BIT_CYC - IR_CYC));
		end
	end

	// line status and interrupts
	always_comb
	begin
		line_status = 8'h00;
		line_status[LS_DR] = rx_data_ready_flag;
		line_status[LS_OE] = overrun;
		line_status[LS_TX_HOLDING_EMPTY_FLAG] = tx_holding_empty_flag;
		line_status[LS_TEMT] = tx_holding_empty_flag && (tx_state == TX_IDLE);
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			tx_holding_empty_flag_q <= 1'b1;
		end
		else
		begin
			tx_holding_empty_flag_q <= tx_holding_empty_flag;
		end
	end

	always_comb
	begin
		events = 3'h0;
		events[EV_RX] = rx_done;
		events[EV_OE] = ov_ev;
		events[EV_TX_HOLDING_EMPTY_FLAG] = tx_holding_empty_flag && !tx_holding_empty_flag_q;
	end

	// a new event wins over a clear in the same cycle
	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			int_stat <= INT_RST;
		end
		else if (bus_req_i.wr && (bus_req_i.addr == INT_CLR_ADDR))
		begin
			int_stat <= (int_stat & ~bus_req_i.wdata[2:0]) | events;
		end
		else
		begin
			int_stat <= int_stat | events;
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			int_en <= INT_RST;
		end
		else if (bus_req_i.wr && (bus_req_i.addr == INT_EN_ADDR))
		begin
			int_en <= bus_req_i.wdata[2:0];
		end
	end

	assign irq_o = |(int_stat & int_en);

	// read data stands for exactly one cycle after the strobe
	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i || !bus_req_i.rd)
		begin
			rd_data_o <= 32'h0000_0000;
		end
		else if (alias_hit)
		begin
			rd_data_o <= {24'h00_0000, fifo_en ? rx_head : receive_buffer};
		end
		else
		begin
			unique case (bus_req_i.addr)
				CTRL_ADDR: rd_data_o <= {30'h0000_0000, fifo_control};
				LSR_ADDR: rd_data_o <= {24'h00_0000, line_status};
				INT_STAT_ADDR: rd_data_o <= {29'h0000_0000, int_stat};
				INT_EN_ADDR: rd_data_o <= {29'h0000_0000, int_en};
				default: rd_data_o <= 32'h0000_0000;
			endcase
		end
	end
endmodule : usd_top

/* File: sim/usd_top_props.sv */
// concurrent checks on the shadow data port pins
`timescale 1ns/1ns
module usd_top_props
	import usd_pkg::*;
(
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// register port
	input wire usd_pkg::usd_bus_req_s bus_req_i,
	input wire logic [31:0] rd_data_o,
	// serial line
	input wire logic serial_input_pin_i,
	input wire logic infrared_rx_input_i,
	input wire logic serial_output_pin_o,
	input wire logic infrared_tx_output_low_o,
	// interrupt
	input wire logic irq_o
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	sequence s_ser_start;
		!serial_output_pin_o [*8];
	endsequence
	sequence s_ir_pulse;
		!infrared_tx_output_low_o [*8] ##1 !infrared_tx_output_low_o [*8] ##1 infrared_tx_output_low_o;
	endsequence

	AST_RD_UPPER_ZERO: assert property (bus_req_i.rd |=> rd_data_o[31:8] == 24'h0)
		else $error("read data upper bits not zero");
	AST_RD_ONE_CYCLE: assert property (!bus_req_i.rd |=> rd_data_o == 32'h0)
		else $error("read data outside its cycle");
	AST_UNMAPPED: assert property (bus_req_i.rd && bus_req_i.addr == ALIAS_BASE + ALIAS_SPAN |=> rd_data_o == 32'h0)
		else $error("read past the aliases not zero");
	AST_IR_SER_QUIET: assert property (!infrared_tx_output_low_o |-> serial_output_pin_o)
		else $error("serial output active during infrared pulse");
	AST_SER_START: assert property ($fell(serial_output_pin_o) |-> s_ser_start)
		else $error("start bit too short");
	AST_IR_PULSE: assert property ($fell(infrared_tx_output_low_o) |-> s_ir_pulse)
		else $error("infrared pulse length wrong");
	AST_RST_IDLE: assert property ($rose(rst_n_i) |-> serial_output_pin_o && infrared_tx_output_low_o && !irq_o)
		else $error("outputs not idle after reset");
	AST_IRQ_MASK: assert property (bus_req_i.wr && bus_req_i.addr == INT_EN_ADDR && bus_req_i.wdata[2:0] == 3'h0 |=> ##1 !irq_o)
		else $error("interrupt not masked");
endmodule : usd_top_props

bind usd_top usd_top_props u_props (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .bus_req_i(bus_req_i),
	.rd_data_o(rd_data_o), .serial_input_pin_i(serial_input_pin_i), .infrared_rx_input_i(infrared_rx_input_i),
	.serial_output_pin_o(serial_output_pin_o), .infrared_tx_output_low_o(infrared_tx_output_low_o), .irq_o(irq_o));

/* File: sim/usd_remote.sv */
// remote serial and infrared transceiver on the line side
`timescale 1ns/1ns
module usd_remote
	import usd_pkg::*;
(
	// clock
	input wire logic sys_clk_i,
	// device outputs
	input wire logic ser_tx_i,
	input wire logic ir_tx_low_i,
	// device inputs
	output logic ser_o,
	output logic ir_o
);
	logic [7:0] rx_q[$];
	logic [7:0] sh;
	int ir_falls;

	initial
	begin
		ser_o = 1'b1;
		ir_o = 1'b0;
		ir_falls = 0;
	end

	// one bit time; an infrared zero is a short high pulse
	task automatic put_bit(input logic v, input logic ir);
		@(posedge sys_clk_i);
		if (ir)
		begin
			ir_o <= !v;
			repeat (IR_CYC) @(posedge sys_clk_i);
			ir_o <= 1'b0;
			repeat (BIT_CYC - IR_CYC - 1) @(posedge sys_clk_i);
		end
		else
		begin
			ser_o <= v;
			repeat (BIT_CYC - 1) @(posedge sys_clk_i);
		end
	endtask : put_bit

	task automatic send(input logic [7:0] b, input logic ir);
		put_bit(1'b0, ir);
		for (int i = 0; i < 8; i++)
			put_bit(b[i], ir);
		put_bit(1'b1, ir);
	endtask : send

	// sample each serial frame sent by the device at bit centres
	always @(negedge ser_tx_i)
	begin
		repeat (HALF_CYC) @(posedge sys_clk_i);
		for (int i = 0; i < 8; i++)
		begin
			repeat (BIT_CYC) @(posedge sys_clk_i);
			sh[i] = ser_tx_i;
		end
		repeat (BIT_CYC) @(posedge sys_clk_i);
		rx_q.push_back(sh);
	end

	always @(negedge ir_tx_low_i)
		ir_falls++;
endmodule : usd_remote

/* File: sim/tb_usd_top.sv */
// self-checking bench for the uart shadow data port
`timescale 1ns/1ns
module tb_usd_top;
	import usd_pkg::*;
	localparam int FRAME = 10 * BIT_CYC + 10;
	logic sys_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	usd_bus_req_s req = '0;
	logic [31:0] rd_data_o;
	logic ser_in;
	logic ir_in;
	logic ser_out;
	logic ir_out;
	logic irq_o;
	int n_mismatch = 0;
	int compares = 0;
	int n;

	always #50 sys_clk_i = ~sys_clk_i;

	usd_top uut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .bus_req_i(req), .rd_data_o(rd_data_o),
		.serial_input_pin_i(ser_in), .infrared_rx_input_i(ir_in), .serial_output_pin_o(ser_out),
		.infrared_tx_output_low_o(ir_out), .irq_o(irq_o));
	usd_remote rem (.sys_clk_i(sys_clk_i), .ser_tx_i(ser_out), .ir_tx_low_i(ir_out), .ser_o(ser_in), .ir_o(ir_in));

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] act);
		compares++;
		if (act !== exp)
		begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", name, exp, act);
		end
	endtask : chk

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge sys_clk_i);
		req.addr <= a;
		req.wdata <= d;
		req.wr <= 1'b1;
		@(posedge sys_clk_i);
		req.wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string name);
		@(posedge sys_clk_i);
		req.addr <= a;
		req.rd <= 1'b1;
		@(posedge sys_clk_i);
		req.rd <= 1'b0;
		@(negedge sys_clk_i);
		chk(name, exp, rd_data_o);
	endtask : rd

	// ends on the falling edge so that outputs launched at the last rising edge have settled
	task automatic wait_cyc(input int k);
		repeat (k) @(posedge sys_clk_i);
		@(negedge sys_clk_i);
	endtask : wait_cyc

	task automatic print_verdict;
		if (n_mismatch == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : print_verdict

	initial
	begin
		wait_cyc(60000);
		n_mismatch++;
		print_verdict();
	end

	initial
	begin
		wait_cyc(20);
		rst_n_i <= 1'b1;
		rd(LSR_ADDR, 32'h60, "lsr reset");
		rd(ALIAS_FIVE, 32'h0, "alias five reset");
		rd(CTRL_ADDR, 32'h0, "ctrl reset");
		rd(ALIAS_BASE + ALIAS_SPAN, 32'h0, "unmapped");
		wr(ALIAS_BASE + ALIAS_SPAN, 32'hff);
		// receive with fifo off, interrupt raised, masked and cleared
		wr(INT_EN_ADDR, 32'h1);
		rem.send(8'h3c, 1'b0);
		wait_cyc(10);
		chk("irq", 32'h1, {31'h0, irq_o});
		rd(INT_STAT_ADDR, 32'h1, "int stat");
		wr(INT_EN_ADDR, 32'h0);
		wait_cyc(2);
		chk("irq masked", 32'h0, {31'h0, irq_o});
		wr(INT_EN_ADDR, 32'h1);
		wait_cyc(2);
		chk("irq unmasked", 32'h1, {31'h0, irq_o});
		wr(INT_CLR_ADDR, 32'h7);
		wait_cyc(2);
		chk("irq cleared", 32'h0, {31'h0, irq_o});
		rd(LSR_ADDR, 32'h61, "lsr data ready");
		rd(ALIAS_SIX, 32'h3c, "rx byte");
		rd(LSR_ADDR, 32'h60, "lsr after read");
		// overrun with fifo off
		rem.send(8'h11, 1'b0);
		rem.send(8'h22, 1'b0);
		wait_cyc(10);
		rd(LSR_ADDR, 32'h63, "lsr overrun");
		rd(INT_STAT_ADDR, 32'h3, "int stat overrun");
		rd(INT_EN_ADDR, 32'h1, "int en");
		rd(ALIAS_BASE, 32'h22, "overwritten byte");
		rd(LSR_ADDR, 32'h60, "lsr overrun cleared");
		// holding byte overwritten with fifo off
		rem.rx_q.delete();
		rd(LSR_ADDR, 32'h60, "lsr before write");
		wr(ALIAS_BASE + 32'h4, 32'hffff_ffa1);
		wr(ALIAS_FIVE, 32'hb2);
		rd(LSR_ADDR, 32'h0, "lsr holding full");
		wr(ALIAS_SIX, 32'hc3);
		wait_cyc(3 * FRAME);
		chk("tx count", 32'h2, rem.rx_q.size());
		chk("tx first", 32'ha1, rem.rx_q[0]);
		chk("tx second", 32'hc3, rem.rx_q[1]);
		// infrared receive and transmit
		wr(CTRL_ADDR, 32'h2);
		rem.send(8'h5a, 1'b1);
		wait_cyc(10);
		rd(ALIAS_FIVE, 32'h5a, "ir rx byte");
		n = rem.ir_falls;
		wr(ALIAS_BASE, 32'h0f);
		wait_cyc(FRAME);
		chk("ir pulses", 32'h5, rem.ir_falls - n);
		// transmit fifo filled past full through all aliases
		wr(CTRL_ADDR, 32'h1);
		rem.rx_q.delete();
		wr(ALIAS_BASE, 32'h40);
		wait_cyc(3);
		for (int i = 0; i < 17; i++)
			wr(ALIAS_BASE + 32'(4 * (i % 16)), 32'h41 + i);
		wait_cyc(18 * FRAME);
		chk("fifo tx count", 32'h11, rem.rx_q.size());
		for (int i = 0; i < 17; i++)
			chk("fifo tx byte", 32'h40 + i, rem.rx_q[i]);
		// receive fifo overrun then drained
		for (int i = 0; i < 17; i++)
			rem.send(8'h80 + 8'(i), 1'b0);
		wait_cyc(10);
		rd(LSR_ADDR, 32'h63, "lsr fifo overrun");
		for (int i = 0; i < 16; i++)
			rd(ALIAS_BASE + 32'(4 * i), 32'h80 + i, "fifo rx byte");
		rd(LSR_ADDR, 32'h60, "lsr fifo drained");
		print_verdict();
	end
endmodule : tb_usd_top
